// >>> include/vbi_consts_consts.svh
// named constants of the blanking-line copy-control and aspect inserter
// assumes a 10 MHz core clock and 8-bit registers reached over a 32-bit APB
`ifndef VBI_CONSTS_CONSTS_SVH
`define VBI_CONSTS_CONSTS_SVH

// register indices, byte address is four times the index
`define IDX_PS_CTRL     8'h12
`define IDX_HD_DATA0    8'h21
`define IDX_HD_DATA1    8'h22
`define IDX_HD_DATA2    8'h23
`define IDX_SD_DATA0    8'h59
`define IDX_SD_DATA1    8'h5A
`define IDX_SD_DATA2    8'h5B
`define IDX_WSS_CTRL    8'h61
`define IDX_MODE        8'h7E
`define IDX_STATUS      8'h7F
`define RST_REG         8'h00

// control bit positions
`define BIT_PS_COPY_EN  6
`define BIT_PS_CRC_EN   7
`define BIT_SD_CRC_EN   4
`define BIT_SD_ODD_EN   5
`define BIT_SD_EVEN_EN  6
`define BIT_WSS_EN      7
`define BIT_WSS_BLANK   7
`define BIT_MODE_PAL    2

// signaling line numbers
`define LINE_525P_COPY  11'h029
`define LINE_SD_ODD     11'h014
`define LINE_SD_EVEN    11'h11B
`define LINE_WSS        11'h017
`define LINE_720P_COPY  11'h018
`define LINE_1080I_A    11'h013
`define LINE_1080I_B    11'h246

// check sequence x^6 + x + 1, preset all ones
`define CRC_SEED        6'h3F
`define CRC_POLY_LOW    6'h03

// wide-screen prefix patterns and bit counts of the copy and wide-screen sequences
`define WSS_RUNIN       8'hAA
`define WSS_START       8'h1E
`define COPY_SEQ_BITS   6'h15
`define WSS_SEQ_BITS    6'h1E

// timing, in ns, and cycle counts derived from the clock period
`define CLK_PERIOD_NS   100
`define DATA_START_NS   11000
`define SD_BIT_NS       2200
`define HD_BIT_NS       1000
`define WSS_BIT_NS      500
`define WSS_VIDEO_NS    42500
`define NS_TO_CYC(ns)   ((((ns) / `CLK_PERIOD_NS) < 1) ? 1 : ((ns) / `CLK_PERIOD_NS))
`define START_CYC       11'(`NS_TO_CYC(`DATA_START_NS))
`define SD_BIT_CYC      11'(`NS_TO_CYC(`SD_BIT_NS))
`define HD_BIT_CYC      11'(`NS_TO_CYC(`HD_BIT_NS))
`define WSS_BIT_CYC     11'(`NS_TO_CYC(`WSS_BIT_NS))
`define WSS_VIDEO_CYC   11'((`WSS_VIDEO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> include/vbi_pkg.sv
// types shared by the blanking-line inserter
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package vbi_pkg;
    // video format selected in the mode register
    typedef enum logic [1:0] {
        FMT_SD    = 2'b00,
        FMT_525P  = 2'b01,
        FMT_720P  = 2'b10,
        FMT_1080I = 2'b11
    } video_fmt_t;

    // kind of signaling carried by the current line
    typedef enum logic [1:0] {
        KIND_NONE    = 2'b00,
        KIND_SD_COPY = 2'b01,
        KIND_HD_COPY = 2'b10,
        KIND_WSS     = 2'b11
    } line_kind_t;

    // line sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_SEND = 2'b10,
        ST_TAIL = 2'b11
    } fsm_t;

    // whole state of the inserter
    typedef struct packed {
        logic [7:0]  ps_ctrl;
        logic [7:0]  hd0;
        logic [7:0]  hd1;
        logic [7:0]  hd2;
        logic [7:0]  sd0;
        logic [7:0]  sd1;
        logic [7:0]  sd2;
        logic [7:0]  wss_ctrl;
        logic [7:0]  mode;
        logic [31:0] prdata;
        fsm_t        fsm;
        line_kind_t  kind;
        logic [31:0] shift;
        logic [5:0]  bits_left;
        logic [10:0] bit_cnt;
        logic [10:0] line_cnt;
        logic        insert;
        logic        level;
    } state_t;
endpackage
`default_nettype wire

// >>> rtl/vbi_copy_and_aspect_inserter.sv
// blanking-line inserter for copy-generation control and wide-screen signaling
// assumes line_i/field_odd_i/line_start_i come synchronous to clk_i from the timing generator
// and that the video mixer replaces the pixel stream by the waveform level while vbi_insert_o is high
//
// Added by the designer: the APB register port.
`include "vbi_consts_consts.svh"
`default_nettype none

module vbi_copy_and_aspect_inserter
    import vbi_pkg::*;
(
    input  wire logic        clk_i,         // 10 MHz core clock
    input  wire logic        arst_n_i,      // asynchronous reset, active low
    input  wire logic        ce_i,          // clock enable, freezes all state when low
    input  wire logic        psel_i,        // apb select
    input  wire logic        penable_i,     // apb access phase
    input  wire logic        pwrite_i,      // apb direction
    input  wire logic [11:0] paddr_i,       // apb byte address
    input  wire logic [31:0] pwdata_i,      // apb write data, low byte used
    output logic      [31:0] prdata_o,      // apb read data
    output logic             pready_o,      // apb ready
    output logic             pslverr_o,     // apb error on unmapped address
    input  wire logic        line_start_i,  // one-cycle pulse at falling hsync edge
    input  wire logic [10:0] line_i,        // number of the line that starts
    input  wire logic        field_odd_i,   // high during odd fields
    output logic             vbi_insert_o,  // waveform replaces video
    output logic             vbi_level_o,   // waveform level, low is blanking
    output logic             vbi_busy_o     // signaling line in progress
);

    state_t st_reg;   // registered state
    state_t st_next;  // next state

    // x^6+x+1 preset ones, bit 0 first
    function automatic logic [5:0] copy_crc(input logic [13:0] data);
        logic [5:0] crc;
        logic       fb;
        crc = `CRC_SEED;
        fb  = 1'b0;
        for (int i = 0; i < 14; i++) begin
            fb  = crc[5] ^ data[i];
            crc = {crc[4:0], 1'b0} ^ (fb ? `CRC_POLY_LOW : 6'h00);
        end
        return crc;
    endfunction

    // build the copy sequence: reference bit then bits 0..19, msb of result sent first
    function automatic logic [31:0] copy_seq(input logic [19:0] raw, input logic crc_en);
        logic [19:0] word;
        logic [5:0]  crc;
        logic [31:0] seq;
        word = raw;
        crc  = copy_crc(raw[13:0]);
        seq  = 32'h00000000;
        if (crc_en) begin
            for (int k = 0; k < 6; k++) begin
                word[14 + k] = crc[5 - k];
            end
        end
        seq[31] = 1'b1;
        for (int j = 0; j < 20; j++) begin
            seq[30 - j] = word[j];
        end
        return seq;
    endfunction

    // build the wide-screen sequence: run-in, start code, bits 0..13
    function automatic logic [31:0] wss_seq(input logic [13:0] raw);
        logic [31:0] seq;
        seq = {`WSS_RUNIN, `WSS_START, 16'h0000};
        for (int j = 0; j < 14; j++) begin
            seq[15 - j] = raw[j];
        end
        return seq;
    endfunction

    // register read mux, unmapped indices read as zero
    function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            `IDX_PS_CTRL:  v = s.ps_ctrl;
            `IDX_HD_DATA0: v = s.hd0;
            `IDX_HD_DATA1: v = s.hd1;
            `IDX_HD_DATA2: v = s.hd2;
            `IDX_SD_DATA0: v = s.sd0;
            `IDX_SD_DATA1: v = s.sd1;
            `IDX_SD_DATA2: v = s.sd2;
            `IDX_WSS_CTRL: v = s.wss_ctrl;
            `IDX_MODE:     v = s.mode;
            `IDX_STATUS:   v = {5'h00, s.fsm != ST_IDLE, s.kind};
            default:       v = 8'h00;
        endcase
        return v;
    endfunction

    // is the index one of the mapped registers
    function automatic logic idx_mapped(input logic [7:0] idx);
        logic m;
        m = 1'b0;
        case (idx)
            `IDX_PS_CTRL, `IDX_HD_DATA0, `IDX_HD_DATA1, `IDX_HD_DATA2,
            `IDX_SD_DATA0, `IDX_SD_DATA1, `IDX_SD_DATA2, `IDX_WSS_CTRL,
            `IDX_MODE, `IDX_STATUS: m = 1'b1;
            default:                m = 1'b0;
        endcase
        return m;
    endfunction

    // decode of the apb address
    logic [7:0] bus_idx;     // register index
    logic       bus_ok;      // aligned and mapped
    logic       wr_strobe;   // write takes effect this edge
    logic       rd_setup;    // read setup phase
    video_fmt_t fmt;         // current format
    line_kind_t new_kind;    // kind of the line now starting
    logic [10:0] bit_cyc;    // bit length for the loaded kind

    assign bus_idx   = paddr_i[9:2];
    assign bus_ok    = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00) && idx_mapped(bus_idx);
    assign wr_strobe = ce_i && psel_i && penable_i && pwrite_i && bus_ok;
    assign rd_setup  = ce_i && psel_i && !penable_i && !pwrite_i;
    assign fmt       = video_fmt_t'(st_reg.mode[1:0]);

    // apb answers in the first access cycle; a frozen block holds the bus
    assign pready_o  = ce_i;
    assign pslverr_o = psel_i && penable_i && !bus_ok;
    assign prdata_o  = st_reg.prdata;

    // insert and level come straight from flip-flops, busy is decoded from the registered state
    assign vbi_insert_o = st_reg.insert;
    assign vbi_level_o  = st_reg.level;
    assign vbi_busy_o   = st_reg.fsm != ST_IDLE;

    // choose what, if anything, the starting line carries
    always_comb begin
        new_kind = KIND_NONE;
        case (fmt)
            FMT_525P: begin
                if (st_reg.ps_ctrl[`BIT_PS_COPY_EN] && line_i == `LINE_525P_COPY) begin
                    new_kind = KIND_HD_COPY;
                end
            end
            FMT_720P: begin
                if (st_reg.ps_ctrl[`BIT_PS_COPY_EN] && line_i == `LINE_720P_COPY) begin
                    new_kind = KIND_HD_COPY;
                end
            end
            FMT_1080I: begin
                if (st_reg.ps_ctrl[`BIT_PS_COPY_EN] &&
                    (line_i == `LINE_1080I_A || line_i == `LINE_1080I_B)) begin
                    new_kind = KIND_HD_COPY;
                end
            end
            FMT_SD: begin
                if (!st_reg.mode[`BIT_MODE_PAL]) begin
                    // odd line 20, even line 283
                    if (field_odd_i && line_i == `LINE_SD_ODD && st_reg.sd0[`BIT_SD_ODD_EN]) begin
                        new_kind = KIND_SD_COPY;
                    end else if (!field_odd_i && line_i == `LINE_SD_EVEN && st_reg.sd0[`BIT_SD_EVEN_EN]) begin
                        new_kind = KIND_SD_COPY;
                    end
                end else begin
                    if (line_i == `LINE_WSS && st_reg.sd0[`BIT_WSS_EN]) begin
                        new_kind = KIND_WSS;
                    end
                end
            end
            default: new_kind = KIND_NONE;
        endcase
    end

    // bit period of the kind being sent
    always_comb begin
        case (st_reg.kind)
            KIND_SD_COPY: bit_cyc = `SD_BIT_CYC;
            KIND_HD_COPY: bit_cyc = `HD_BIT_CYC;
            KIND_WSS:     bit_cyc = `WSS_BIT_CYC;
            default:      bit_cyc = `HD_BIT_CYC;
        endcase
    end

    // next-state logic: register file, apb read data and line sequencer
    always_comb begin
        st_next = st_reg;
        // read data is latched in the setup cycle so it is stable through access
        if (rd_setup) begin
            st_next.prdata = {24'h000000, bus_ok ? reg_read(st_reg, bus_idx) : 8'h00};
        end
        // register writes happen only on the completing access edge
        if (wr_strobe) begin
            case (bus_idx)
                `IDX_PS_CTRL:  st_next.ps_ctrl  = pwdata_i[7:0];
                `IDX_HD_DATA0: st_next.hd0      = pwdata_i[7:0];
                `IDX_HD_DATA1: st_next.hd1      = pwdata_i[7:0];
                `IDX_HD_DATA2: st_next.hd2      = pwdata_i[7:0];
                `IDX_SD_DATA0: st_next.sd0      = pwdata_i[7:0];
                `IDX_SD_DATA1: st_next.sd1      = pwdata_i[7:0];
                `IDX_SD_DATA2: st_next.sd2      = pwdata_i[7:0];
                `IDX_WSS_CTRL: st_next.wss_ctrl = pwdata_i[7:0];
                `IDX_MODE:     st_next.mode     = pwdata_i[7:0];
                default:       st_next.mode     = st_reg.mode;
            endcase
        end
        // a new line always restarts the sequencer, so a lost sync cannot hang it
        if (line_start_i) begin
            st_next.kind     = new_kind;
            st_next.line_cnt = 11'h000;
            st_next.bit_cnt  = 11'h000;
            st_next.level    = 1'b0;
            // blanking before signaling, video restored after the last bit or, on a wide-screen line, at the video point
            st_next.insert   = new_kind != KIND_NONE;
            st_next.fsm      = (new_kind == KIND_NONE) ? ST_IDLE : ST_LEAD;
            case (new_kind)
                // raw register bits when check generation is off
                KIND_SD_COPY: begin
                    st_next.shift     = copy_seq({st_reg.sd0[3:0], st_reg.sd1, st_reg.sd2},
                                                 st_reg.sd0[`BIT_SD_CRC_EN]);
                    st_next.bits_left = `COPY_SEQ_BITS;
                end
                KIND_HD_COPY: begin
                    st_next.shift     = copy_seq({st_reg.hd0[3:0], st_reg.hd1, st_reg.hd2},
                                                 st_reg.ps_ctrl[`BIT_PS_CRC_EN]);
                    st_next.bits_left = `COPY_SEQ_BITS;
                end
                KIND_WSS: begin
                    st_next.shift     = wss_seq({st_reg.sd1[5:0], st_reg.sd2});
                    st_next.bits_left = `WSS_SEQ_BITS;
                end
                default: begin
                    st_next.shift     = 32'h00000000;
                    st_next.bits_left = 6'h00;
                end
            endcase
        end else begin
            if (st_reg.fsm != ST_IDLE) begin
                st_next.line_cnt = st_reg.line_cnt + 11'h001;
            end
            case (st_reg.fsm)
                ST_IDLE: begin
                    st_next.insert = 1'b0;
                    st_next.level  = 1'b0;
                end
                ST_LEAD: begin
                    // blanking level until the data start point
                    if (st_reg.line_cnt == `START_CYC - 11'h001) begin
                        st_next.fsm     = ST_SEND;
                        st_next.bit_cnt = 11'h000;
                        st_next.level   = st_reg.shift[31] &&
                                          !(st_reg.kind == KIND_WSS && st_reg.wss_ctrl[`BIT_WSS_BLANK]);
                    end
                end
                ST_SEND: begin
                    st_next.bit_cnt = st_reg.bit_cnt + 11'h001;
                    if (st_reg.bit_cnt == bit_cyc - 11'h001) begin
                        st_next.bit_cnt   = 11'h000;
                        st_next.shift     = {st_reg.shift[30:0], 1'b0};
                        st_next.bits_left = st_reg.bits_left - 6'h01;
                        st_next.level     = st_reg.shift[30] &&
                                            !(st_reg.kind == KIND_WSS && st_reg.wss_ctrl[`BIT_WSS_BLANK]);
                        if (st_reg.bits_left == 6'h01) begin
                            st_next.level = 1'b0;
                            // wide-screen line holds blanking to the video point
                            if (st_reg.kind == KIND_WSS) begin
                                st_next.fsm = ST_TAIL;
                            end else begin
                                st_next.fsm    = ST_IDLE;
                                st_next.insert = 1'b0;
                                st_next.kind   = KIND_NONE;
                            end
                        end
                    end
                end
                ST_TAIL: begin
                    if (st_reg.line_cnt >= `WSS_VIDEO_CYC - 11'h001) begin
                        st_next.fsm    = ST_IDLE;
                        st_next.insert = 1'b0;
                        st_next.kind   = KIND_NONE;
                    end
                end
                default: st_next.fsm = ST_IDLE;
            endcase
        end
    end

    // state register; the clock enable freezes everything
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg           <= '0;
            st_reg.ps_ctrl   <= `RST_REG;
            st_reg.hd0       <= `RST_REG;
            st_reg.hd1       <= `RST_REG;
            st_reg.hd2       <= `RST_REG;
            st_reg.sd0       <= `RST_REG;
            st_reg.sd1       <= `RST_REG;
            st_reg.sd2       <= `RST_REG;
            st_reg.wss_ctrl  <= `RST_REG;
            st_reg.mode      <= `RST_REG;
            st_reg.fsm       <= ST_IDLE;
            st_reg.kind      <= KIND_NONE;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

endmodule
`default_nettype wire

// >>> bench/vbi_inserter_assertions.sv
// port assertions of the blanking-line inserter
// assumes the inserter's register map and one clock domain
`include "vbi_consts_consts.svh"
`default_nettype none
module vbi_inserter_checker (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        ce_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        line_start_i,
    input wire logic        vbi_insert_o,
    input wire logic        vbi_level_o,
    input wire logic        vbi_busy_o
);
    logic        ok;  // access hits a mapped, aligned word
    logic [15:0] run; // cycles the waveform has replaced video
    assign ok = paddr_i[1:0] == 2'h0 && paddr_i[11:10] == 2'h0 && paddr_i[9:2] inside {`IDX_PS_CTRL,
        `IDX_HD_DATA0, `IDX_HD_DATA1, `IDX_HD_DATA2, `IDX_SD_DATA0, `IDX_SD_DATA1, `IDX_SD_DATA2,
        `IDX_WSS_CTRL, `IDX_MODE, `IDX_STATUS};
    // run length, cleared whenever video shows again
    always_ff @(posedge clk_i or negedge arst_n_i)
        if (!arst_n_i) run <= 16'h0000;
        else run <= vbi_insert_o ? run + 16'h0001 : 16'h0000;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_ready; pready_o == ce_i; endproperty
    a_ready: assert property (p_ready) else $error("ready not following enable");
    property p_err; psel_i && penable_i && !ok |-> pslverr_o; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_noerr; psel_i && penable_i && ok |-> !pslverr_o; endproperty
    a_noerr: assert property (p_noerr) else $error("mapped access refused");
    property p_rdzero; psel_i && penable_i && !pwrite_i && !ok |-> prdata_o == 32'h0000_0000; endproperty
    a_rdzero: assert property (p_rdzero) else $error("unmapped read not zero");
    property p_upper; prdata_o[31:8] == 24'h00_0000; endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits set");
    property p_cause; $rose(vbi_insert_o) |-> $past(line_start_i); endproperty
    a_cause: assert property (p_cause) else $error("insert without line start");
    property p_lead; $rose(vbi_insert_o) |-> !vbi_level_o [*8]; endproperty
    a_lead: assert property (p_lead) else $error("no blanking before bits");
    property p_len; $fell(vbi_insert_o) |-> run inside {16'h023C, 16'h0140, 16'h01A9}; endproperty
    a_len: assert property (p_len) else $error("insert length wrong");
    property p_level; vbi_level_o |-> vbi_insert_o; endproperty
    a_level: assert property (p_level) else $error("level outside insert");
    property p_busy; vbi_insert_o |-> vbi_busy_o; endproperty
    a_busy: assert property (p_busy) else $error("insert while idle");
    c_sd: cover property ($fell(vbi_insert_o) && run == 16'h023C);
    c_hd: cover property ($fell(vbi_insert_o) && run == 16'h0140);
    c_wss: cover property ($fell(vbi_insert_o) && run == 16'h01A9);
endmodule
bind vbi_copy_and_aspect_inserter vbi_inserter_checker u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .line_start_i(line_start_i),
    .vbi_insert_o(vbi_insert_o), .vbi_level_o(vbi_level_o), .vbi_busy_o(vbi_busy_o));
`default_nettype wire

// >>> bench/vbi_video_sink.sv
// recorder on the dac side: samples each bit of a signaling line
// assumes the bench sets bit period and bit count before each line
`default_nettype none
module vbi_video_sink (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        line_start_i,
    input  wire logic        insert_i,
    input  wire logic        level_i,
    input  wire logic [5:0]  bit_cyc_i,
    input  wire logic [5:0]  nbits_i,
    output logic      [31:0] word_o,
    output logic      [15:0] len_o,
    output logic             done_o
);
    logic [15:0] cnt;   // cycles since line start
    logic [5:0]  k;     // bits taken so far
    logic        armed; // a line is being watched
    logic        ins_q; // insert one cycle back
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {cnt, k, armed, ins_q, word_o, len_o, done_o} <= '0;
        end else begin
            ins_q <= insert_i;
            done_o <= armed && ins_q && !insert_i;
            if (line_start_i) begin
                {cnt, k, word_o, len_o} <= '0;
                armed <= 1'b1;
            end else begin
                cnt <= cnt + 16'h0001;
                if (insert_i) len_o <= len_o + 16'h0001;
                // sample mid-bit so a one-cycle skew cannot flip a bit
                if (k < nbits_i && cnt == 16'h006E + 16'(k) * 16'(bit_cyc_i) + 16'(bit_cyc_i / 6'h02)) begin
                    word_o <= {word_o[30:0], level_i};
                    k <= k + 6'h01;
                end
                if (ins_q && !insert_i) armed <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/vbi_copy_and_aspect_inserter_bench.sv
// self-checking bench of the blanking-line inserter
// assumes the bound checker and the sink model on the video side
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module vbi_copy_and_aspect_inserter_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, arst_n_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic        line_start_i, field_odd_i, vbi_insert_o, vbi_level_o, vbi_busy_o, done;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, word;
    logic [10:0] line_i;
    logic [5:0]  bit_cyc, nbits;
    logic [15:0] len;
    logic [19:0] c;          // copy payload c0 at bit 0
    logic [13:0] b;          // aspect payload
    logic [7:0]  d;
    logic [63:0] exp_q[$], note; // notes, oldest first
    int          mismatches, checked, cycles;
    int          seed = 32'hB225C19E;
    localparam logic [7:0]  REGS [10] = '{8'h12, 8'h21, 8'h22, 8'h23, 8'h59, 8'h5A, 8'h5B, 8'h61, 8'h7E, 8'h7F};
    localparam logic [12:0] HD [4] = '{{2'h1, 11'h029}, {2'h2, 11'h018}, {2'h3, 11'h013}, {2'h3, 11'h246}};
    vbi_copy_and_aspect_inserter u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .line_start_i(line_start_i), .line_i(line_i),
        .field_odd_i(field_odd_i), .vbi_insert_o(vbi_insert_o), .vbi_level_o(vbi_level_o), .vbi_busy_o(vbi_busy_o));
    vbi_video_sink u_sink (.clk_i(clk_i), .arst_n_i(arst_n_i), .line_start_i(line_start_i), .insert_i(vbi_insert_o),
        .level_i(vbi_level_o), .bit_cyc_i(bit_cyc), .nbits_i(nbits), .word_o(word), .len_o(len), .done_o(done));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic finish_test;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, well above the whole sequence
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    // oldest note against each read or each finished line
    always @(posedge clk_i) begin
        if ((psel_i && penable_i && pready_o && !pwrite_i) || done) begin
            note = exp_q.size() > 0 ? exp_q.pop_front() : 64'hx;
            `CHK("result", note, (done ? {word, 16'h0000, len} : {31'h0, pslverr_o, prdata_o}))
        end
    end
    // one apb transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] v);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= {24'h00_0000, v};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic e, input logic [7:0] v);
        exp_q.push_back({31'h0, e, 24'h00_0000, v});
        apb(1'b0, idx, 8'h00);
    endtask
    // one video line; the sink is told what bit timing to expect
    task automatic line(input logic [10:0] n, input logic odd, input logic [5:0] bc, input logic [5:0] nb,
                        input logic on, input logic [31:0] w, input logic [15:0] l);
        bit_cyc <= bc;
        nbits <= nb;
        line_i <= n;
        field_odd_i <= odd;
        line_start_i <= 1'b1;
        if (on) exp_q.push_back({w, 16'h0000, l});
        @(posedge clk_i);
        line_start_i <= 1'b0;
        @(posedge clk_i);
        `CHK("busy", on, vbi_busy_o)
        repeat (640) @(posedge clk_i);
    endtask
    // reference bit then c0 first; crc preset all ones, x^6+x+1
    function automatic logic [31:0] cw(input logic [19:0] v, input logic crc_on);
        logic [5:0]  r;
        logic [31:0] w;
        r = 6'h3F;
        w = 32'h0010_0000;
        for (int i = 0; i < 14; i++) r = {r[4:0], 1'b0} ^ ((r[5] ^ v[i]) ? 6'h03 : 6'h00);
        for (int i = 0; i < 6; i++) if (crc_on) v[14 + i] = r[5 - i];
        for (int i = 0; i < 20; i++) w[19 - i] = v[i];
        return w;
    endfunction
    initial begin
        {psel_i, penable_i, pwrite_i, line_start_i, field_odd_i, arst_n_i} = '0;
        {paddr_i, pwdata_i, line_i, bit_cyc, nbits, mismatches, checked, cycles} = '0;
        ce_i = 1'b1;
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        // reset values, unmapped word, read-only status
        foreach (REGS[i]) rd(REGS[i], 1'b0, 8'h00);
        rd(8'h00, 1'b1, 8'h00);
        apb(1'b1, 8'h7F, 8'hFF);
        rd(8'h7F, 1'b0, 8'h00);
        for (int i = 1; i < 7; i++) begin
            d = 8'($random(seed));
            apb(1'b1, REGS[i], d);
            rd(REGS[i], 1'b0, d);
        end
        // progressive and hd formats share enable and data
        c = 20'($random(seed));
        apb(1'b1, 8'h21, {4'h0, c[19:16]});
        apb(1'b1, 8'h22, c[15:8]);
        apb(1'b1, 8'h23, c[7:0]);
        apb(1'b1, 8'h12, 8'h40);
        foreach (HD[i]) begin
            apb(1'b1, 8'h7E, {6'h00, HD[i][12:11]});
            line(HD[i][10:0], 1'b1, 6'h0A, 6'h15, 1'b1, cw(c, 1'b0), 16'h0140);
        end
        line(11'h029, 1'b1, 6'h0A, 6'h15, 1'b0, 32'h0, 16'h0);
        apb(1'b1, 8'h7E, 8'h01);
        apb(1'b1, 8'h12, 8'hC0);
        line(11'h029, 1'b1, 6'h0A, 6'h15, 1'b1, cw(c, 1'b1), 16'h0140);
        apb(1'b1, 8'h12, 8'h80);
        line(11'h029, 1'b1, 6'h0A, 6'h15, 1'b0, 32'h0, 16'h0);
        // standard definition, field gates and crc
        apb(1'b1, 8'h7E, 8'h00);
        apb(1'b1, 8'h5A, c[15:8]);
        apb(1'b1, 8'h5B, c[7:0]);
        apb(1'b1, 8'h59, {4'h3, c[19:16]});
        line(11'h014, 1'b1, 6'h16, 6'h15, 1'b1, cw(c, 1'b1), 16'h023C);
        line(11'h11B, 1'b0, 6'h16, 6'h15, 1'b0, 32'h0, 16'h0);
        apb(1'b1, 8'h59, {4'h4, c[19:16]});
        line(11'h11B, 1'b0, 6'h16, 6'h15, 1'b1, cw(c, 1'b0), 16'h023C);
        line(11'h014, 1'b1, 6'h16, 6'h15, 1'b0, 32'h0, 16'h0);
        apb(1'b1, 8'h7E, 8'h04);
        line(11'h11B, 1'b0, 6'h16, 6'h15, 1'b0, 32'h0, 16'h0);
        // aspect word: software loads odd parity into bit 3
        b = 14'($random(seed));
        b[3] = ~^b[2:0];
        apb(1'b1, 8'h5A, {2'b00, b[13:8]});
        apb(1'b1, 8'h5B, b[7:0]);
        apb(1'b1, 8'h59, 8'h80);
        line(11'h017, 1'b0, 6'h05, 6'h1E, 1'b1, {2'b00, 16'hAA1E, {<<{b}}}, 16'h01A9);
        apb(1'b1, 8'h61, 8'h80);
        line(11'h017, 1'b1, 6'h05, 6'h1E, 1'b1, 32'h0, 16'h01A9);
        apb(1'b1, 8'h7E, 8'h00);
        line(11'h017, 1'b0, 6'h05, 6'h1E, 1'b0, 32'h0, 16'h0);
        apb(1'b1, 8'h7E, 8'h04);
        apb(1'b1, 8'h59, 8'h00);
        line(11'h017, 1'b0, 6'h05, 6'h1E, 1'b0, 32'h0, 16'h0);
        finish_test();
    end
endmodule
`default_nettype wire
